//--- tb/csaf_master_model.sv
/*
 Network master model: issues one service-data request at a time.
 Assumes the bench calls send from the falling edge of mclk.
*/
`timescale 1ns/1ns
`default_nettype none
module csaf_master_model (
	input wire logic mclk,
	output logic req_valid,
	output logic [7:0] req_cmd,
	output logic [15:0] req_index,
	output logic [7:0] req_subindex,
	output logic [31:0] req_data
);
	initial begin
		req_valid = 1'b0;
		req_cmd = 8'h00;
		req_index = 16'h0000;
		req_subindex = 8'h00;
		req_data = 32'h0000_0000;
	end
	// Released command and data lines are inverted so a stale value is never mistaken for data; index and sub-index keep their value
	task send(input logic [7:0] c, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d);
		@(negedge mclk);
		req_valid = 1'b1;
		req_cmd = c;
		req_index = i;
		req_subindex = s;
		req_data = d;
		@(negedge mclk);
		req_valid = 1'b0;
		req_cmd = ~c;
		req_data = ~d;
	endtask : send
endmodule : csaf_master_model
`default_nettype wire

//--- tb/csaf_tb_top.sv
/*
 Self-checking bench for the access checker and fault reporter.
 Assumes inputs change on the falling edge and outputs settle by then.
*/
`timescale 1ns/1ns
`default_nettype none
module canopen_sdo_abort_fault_report_tb_top import csaf_pkg::*;;
	logic mclk, arst_n, req_valid, req_is_map, od_type_ok, mrv, fault_clear, pse;
	logic resp_valid, od_write, fault_valid, fault_active;
	logic [7:0] req_cmd, req_subindex, od_desc, mode_req, resp_cmd, map_bits;
	logic [3:0] map_count;
	logic [15:0] req_index, modes_supported, fault_code;
	logic [31:0] req_data, od_upper, od_lower, od_read_data, resp_data, od_write_data, fault_aux;
	logic [6:0] flt;
	int num_errors, tests_run, cycles;

	csaf_master_model m_u (.mclk(mclk), .req_valid(req_valid), .req_cmd(req_cmd),
		.req_index(req_index), .req_subindex(req_subindex), .req_data(req_data));
	csaf_checker dut_u (.mclk(mclk), .arst_n(arst_n), .req_valid(req_valid), .req_cmd(req_cmd),
		.req_index(req_index), .req_subindex(req_subindex), .req_data(req_data),
		.req_is_map(req_is_map), .map_count(map_count), .map_bits(map_bits), .od_desc(od_desc),
		.od_type_ok(od_type_ok), .od_upper(od_upper), .od_lower(od_lower),
		.od_read_data(od_read_data), .mode_request(mode_req), .mode_request_valid(mrv),
		.fault_invalid_enable_request(flt[0]), .fault_master_lost_guarding(flt[1]),
		.fault_master_lost_heartbeat(flt[2]), .fault_index_pulse_lost(flt[4]),
		.position_deviation(flt[5]), .power_stage_enabled(pse),
		.fault_internal_write_error(flt[6]), .fault_clear(fault_clear),
		.resp_valid(resp_valid), .resp_cmd(resp_cmd), .resp_data(resp_data),
		.od_write(od_write), .od_write_data(od_write_data), .modes_supported(modes_supported),
		.fault_valid(fault_valid), .fault_code(fault_code), .fault_aux(fault_aux),
		.fault_active(fault_active));

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	task complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : complete_run

	// A hang costs at most a few thousand cycles
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			complete_run();
		end
	end

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task sdo(input logic [7:0] c, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
		input logic [7:0] desc, input logic [31:0] ab);
		logic up;
		logic [31:0] rd;
		up = (c == 8'h40);
		rd = (i == 16'h6502) ? 32'h0000_006D : od_read_data;
		od_desc = desc;
		m_u.send(c, i, s, d);
		chk("resp_valid", 32'h1, {31'h0, resp_valid});
		chk("resp_cmd", (ab != 0) ? 32'h80 : (up ? 32'h43 : 32'h60), {24'h0, resp_cmd});
		chk("resp_data", (ab != 0) ? ab : (up ? rd : 32'h0), resp_data);
		chk("od_write", {31'h0, ab == 0 && !up}, {31'h0, od_write});
		if (ab == 0 && !up)
			chk("od_write_data", d, od_write_data);
	endtask : sdo

	task t_access;
		sdo(8'h23, 16'h6040, 8'h01, 32'h64, 8'h37, 32'h0);
		sdo(8'h2B, 16'h6040, 8'h01, 32'h64, 8'h2F, 32'h0);
		sdo(8'h2F, 16'h6040, 8'h01, 32'h64, 8'h27, 32'h0);
		sdo(8'h40, 16'h6040, 8'h01, 32'h0, 8'h37, 32'h0);
		sdo(8'h22, 16'h6040, 8'h01, 32'h64, 8'h36, CSAF_AB_BAD_CS);
		sdo(8'h60, 16'h6040, 8'h01, 32'h64, 8'h37, CSAF_AB_BAD_CS);
		sdo(8'h23, 16'h6040, 8'h01, 32'h64, 8'h36, CSAF_AB_NO_OBJECT);
		sdo(8'h23, 16'h6040, 8'h02, 32'h64, 8'h37, CSAF_AB_NO_SUBINDEX);
		sdo(8'h23, 16'h6040, 8'h01, 32'h64, 8'h35, CSAF_AB_READ_ONLY);
		sdo(8'h2F, 16'h6040, 8'h01, 32'h64, 8'h37, CSAF_AB_LEN_MISMATCH);
		sdo(8'h23, 16'h6040, 8'h01, 32'h3E8, 8'h37, 32'h0);
		sdo(8'h23, 16'h6040, 8'h01, 32'h3E9, 8'h37, CSAF_AB_TOO_HIGH);
		sdo(8'h23, 16'h6040, 8'h01, 32'h9, 8'h37, CSAF_AB_TOO_LOW);
		od_type_ok = 1'b0;
		sdo(8'h23, 16'h6040, 8'h01, 32'h64, 8'h37, CSAF_AB_TYPE_MISMATCH);
		od_type_ok = 1'b1;
		req_is_map = 1'b1;
		sdo(8'h23, 16'h6040, 8'h01, 32'h64, 8'h33, CSAF_AB_NOT_MAPPABLE);
		map_count = 4'h8;
		map_bits = 8'h40;
		sdo(8'h23, 16'h6040, 8'h01, 32'h64, 8'h37, 32'h0);
		map_count = 4'h9;
		sdo(8'h23, 16'h6040, 8'h01, 32'h64, 8'h37, CSAF_AB_MAP_TOO_LONG);
		map_count = 4'h2;
		map_bits = 8'h41;
		sdo(8'h23, 16'h6040, 8'h01, 32'h64, 8'h37, CSAF_AB_MAP_TOO_LONG);
		req_is_map = 1'b0;
	endtask : t_access

	task t_modes;
		chk("modes_supported", 32'h6D, {16'h0, modes_supported});
		sdo(8'h40, 16'h6502, 8'h00, 32'h0, 8'h0D, 32'h0);
		sdo(8'h2B, 16'h6502, 8'h00, 32'h6D, 8'h0D, CSAF_AB_READ_ONLY);
		mode_req = 8'h00;
		mrv = 1'b1;
		@(negedge mclk);
		mrv = 1'b0;
		@(negedge mclk);
		chk("fault_active", 32'h0, {31'h0, fault_active});
	endtask : t_modes

	task t_fault(input int b, input logic [15:0] ec, input logic [31:0] ax);
		@(negedge mclk);
		if (b == 3)
			mrv = 1'b1;
		else
			flt[b] = 1'b1;
		@(negedge mclk);
		mrv = 1'b0;
		flt = 7'h00;
		@(negedge mclk);
		// The level is registered from the latch, so it rises with the report pulse
		chk("fault_active", 32'h1, {31'h0, fault_active});
		chk("fault_valid", 32'h1, {31'h0, fault_valid});
		chk("fault_code", {16'h0, ec}, {16'h0, fault_code});
		chk("fault_aux", ax, fault_aux);
		fault_clear = 1'b1;
		@(negedge mclk);
		fault_clear = 1'b0;
		@(negedge mclk);
		chk("fault_cleared", 32'h0, {31'h0, fault_active});
	endtask : t_fault

	task t_faults;
		flt[5] = 1'b1;
		@(negedge mclk);
		flt[5] = 1'b0;
		@(negedge mclk);
		chk("deviation_disabled", 32'h0, {31'h0, fault_active});
		pse = 1'b1;
		mode_req = 8'h01;
		t_fault(0, CSAF_EC_INVALID_ENABLE, CSAF_AX_INVALID_ENABLE);
		t_fault(1, CSAF_EC_LOST_GUARD, CSAF_AX_LOST_GUARD);
		t_fault(2, CSAF_EC_LOST_HBEAT, CSAF_AX_LOST_HBEAT);
		t_fault(3, CSAF_EC_MODE_UNSUP, CSAF_AX_MODE_UNSUP);
		t_fault(4, CSAF_EC_INDEX_PULSE, CSAF_AX_INDEX_PULSE);
		t_fault(5, CSAF_EC_POS_DEV, CSAF_AX_POS_DEV);
		t_fault(6, CSAF_EC_INTERNAL_WRITE, CSAF_AX_INTERNAL_WRITE);
	endtask : t_faults

	initial begin
		arst_n = 1'b0;
		{req_is_map, mrv, fault_clear, pse} = 4'h0;
		od_type_ok = 1'b1;
		map_count = 4'h1;
		map_bits = 8'h20;
		od_desc = 8'h37;
		mode_req = 8'h00;
		flt = 7'h00;
		od_upper = 32'h3E8;
		od_lower = 32'hA;
		od_read_data = 32'h1234_ABCD;
		repeat (5) @(negedge mclk);
		chk("modes_in_reset", 32'h0, {16'h0, modes_supported});
		arst_n = 1'b1;
		@(negedge mclk);
		t_modes();
		t_access();
		t_faults();
		complete_run();
	end
endmodule : canopen_sdo_abort_fault_report_tb_top
`default_nettype wire

//--- verilog/csaf_checker.sv
/*
 Service-data access checker and fault reporter.
 A request (specifier, index, sub-index, data, length) is checked against
 an object descriptor supplied by the dictionary; the answer is either the
 normal confirmation, with a write strobe on downloads, or an abort code with no write.
 Drive fault events are latched and reported as error/auxiliary code pairs.
 Assumes fault and request inputs come from logic on mclk; guarding and
 heartbeat timeouts are pulses from the supervision timers.
*/
// Summary of operation
// RULE1: Only specifiers 40,2F,2B,23; else abort 05040001
// RULE2: Write to read-only object aborts 06010002
// RULE3: Missing index aborts 06020000
// RULE4: Missing sub-index aborts 06090011
// RULE5: Non-mappable object into mapping aborts 06040041
// RULE6: Over-long mapping aborts 06040042
// RULE7: Written length mismatch aborts 06070010
// RULE8: Type or parameter length mismatch aborts 06070012
// RULE9: Value above upper limit aborts 06090031
// RULE10: Value below lower limit aborts 06090032
// RULE11: Faults carry 16-bit code, 32-bit auxiliary; enable 600D
// RULE12: Guarding lifetime expiry: 6064 / 00000E20
// RULE13: Heartbeat consumer timeout: 6065 / 00000E21
// RULE14: Unsupported mode request: 605A / 00000E05
// RULE15: Index pulse loss: 604A / 00000C92
// RULE16: Deviation while enabled: 6051 / 00000D01
// RULE17: Internal write failure: 603B / 00000BF2
// RULE18: Read-only supported-mode word, bit marks mode
// RULE19: Abort leaves object unchanged, replaces confirmation
`timescale 1ns/1ns
`default_nettype none
module csaf_checker
	import csaf_pkg::*;
#(
	parameter int MAP_BITS = CSAF_PDO_MAX_BITS,
	parameter int MAP_OBJECTS = CSAF_PDO_MAX_OBJECTS
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic req_valid,
	input wire logic [7:0] req_cmd,
	input wire logic [15:0] req_index,
	input wire logic [7:0] req_subindex,
	input wire logic [31:0] req_data,
	input wire logic req_is_map,
	input wire logic [3:0] map_count,
	input wire logic [7:0] map_bits,
	input wire logic [7:0] od_desc,
	input wire logic od_type_ok,
	input wire logic [31:0] od_upper,
	input wire logic [31:0] od_lower,
	input wire logic [31:0] od_read_data,
	input wire logic [7:0] mode_request,
	input wire logic mode_request_valid,
	input wire logic fault_invalid_enable_request,
	input wire logic fault_master_lost_guarding,
	input wire logic fault_master_lost_heartbeat,
	input wire logic fault_index_pulse_lost,
	input wire logic position_deviation,
	input wire logic power_stage_enabled,
	input wire logic fault_internal_write_error,
	input wire logic fault_clear,
	output logic resp_valid,
	output logic [7:0] resp_cmd,
	output logic [31:0] resp_data,
	output logic od_write,
	output logic [31:0] od_write_data,
	output logic [15:0] modes_supported,
	output logic fault_valid,
	output logic [15:0] fault_code,
	output logic [31:0] fault_aux,
	output logic fault_active
);
	// Request check
	logic [31:0] abort_c;
	logic is_write, exists, sub_ok;
	logic [2:0] len_bytes, obj_bytes;
	logic resp_valid_q, resp_valid_d, od_write_q, od_write_d;
	logic [7:0] resp_cmd_q, resp_cmd_d;
	logic [31:0] resp_data_q, resp_data_d, wdata_q, wdata_d;

	always_comb begin
		is_write = (req_cmd != CSAF_CS_UPLOAD);
		exists = od_desc[CSAF_OD_EXISTS];
		sub_ok = (req_subindex <= {5'h00, od_desc[CSAF_OD_MAXSUB_LO +: 3]});
		case (req_cmd)
			CSAF_CS_DNLD1: len_bytes = 3'h1;
			CSAF_CS_DNLD2: len_bytes = 3'h2;
			default: len_bytes = 3'h4;
		endcase
		case (csaf_size_e'(od_desc[CSAF_OD_SIZE_LO +: 2]))
			CSAF_SZ_1: obj_bytes = 3'h1;
			CSAF_SZ_2: obj_bytes = 3'h2;
			CSAF_SZ_4: obj_bytes = 3'h4;
			default: obj_bytes = 3'h0;
		endcase
		// Priority runs from the frame outward to the value
		abort_c = CSAF_AB_NONE;
		if (!(req_cmd == CSAF_CS_UPLOAD || req_cmd == CSAF_CS_DNLD1 ||
			req_cmd == CSAF_CS_DNLD2 || req_cmd == CSAF_CS_DNLD4)) begin
			abort_c = CSAF_AB_BAD_CS; // RULE1
		end else if (!exists) begin
			abort_c = CSAF_AB_NO_OBJECT; // RULE3
		end else if (!sub_ok) begin
			abort_c = CSAF_AB_NO_SUBINDEX; // RULE4
		end else if (is_write && (req_index == CSAF_MODES_INDEX || !od_desc[CSAF_OD_WRITABLE])) begin
			abort_c = CSAF_AB_READ_ONLY; // RULE2 RULE18
		end else if (is_write && !od_type_ok) begin
			abort_c = CSAF_AB_TYPE_MISMATCH; // RULE8
		end else if (is_write && len_bytes != obj_bytes) begin
			abort_c = CSAF_AB_LEN_MISMATCH; // RULE7
		end else if (is_write && req_is_map && !od_desc[CSAF_OD_MAPPABLE]) begin
			abort_c = CSAF_AB_NOT_MAPPABLE; // RULE5
		end else if (is_write && req_is_map &&
			(32'(map_count) > 32'(MAP_OBJECTS) || 32'(map_bits) > 32'(MAP_BITS))) begin
			abort_c = CSAF_AB_MAP_TOO_LONG; // RULE6
		end else if (is_write && req_data > od_upper) begin
			abort_c = CSAF_AB_TOO_HIGH; // RULE9
		end else if (is_write && req_data < od_lower) begin
			abort_c = CSAF_AB_TOO_LOW; // RULE10
		end
	end

	always_comb begin
		resp_valid_d = req_valid;
		od_write_d = 1'b0;
		wdata_d = wdata_q;
		resp_cmd_d = resp_cmd_q;
		resp_data_d = resp_data_q;
		if (req_valid) begin
			if (abort_c != CSAF_AB_NONE) begin
				// No write strobe on abort, so the object keeps its value
				resp_cmd_d = CSAF_CS_ABORT; // RULE19
				resp_data_d = abort_c; // RULE19
			end else if (is_write) begin
				resp_cmd_d = CSAF_CS_DNLD_ACK;
				resp_data_d = 32'h0000_0000;
				od_write_d = 1'b1;
				wdata_d = req_data;
			end else begin
				resp_cmd_d = CSAF_CS_UPLD_ACK;
				resp_data_d = (req_index == CSAF_MODES_INDEX) ?
					{16'h0000, CSAF_MODES_SUPPORTED} : od_read_data; // RULE18
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			resp_valid_q <= 1'b0;
			resp_cmd_q <= 8'h00;
			resp_data_q <= 32'h0000_0000;
			od_write_q <= 1'b0;
			wdata_q <= 32'h0000_0000;
		end else begin
			resp_valid_q <= resp_valid_d;
			resp_cmd_q <= resp_cmd_d;
			resp_data_q <= resp_data_d;
			od_write_q <= od_write_d;
			wdata_q <= wdata_d;
		end
	end

	// Fault reporting
	logic [CSAF_NUM_FAULTS-1:0] ev, act, fresh;
	logic [15:0] ec_tab [CSAF_NUM_FAULTS];
	logic [31:0] ax_tab [CSAF_NUM_FAULTS];
	logic mode_bad;
	logic fv_q, fv_d, fa_q, fa_d;
	logic [15:0] fc_q, fc_d, ms_q, ms_d;
	logic [31:0] fx_q, fx_d;

	always_comb begin
		mode_bad = mode_request_valid &&
			(mode_request > 8'h0F || !CSAF_MODES_SUPPORTED[mode_request[3:0]]); // RULE14 RULE18
		ev[0] = fault_invalid_enable_request; // RULE11
		ev[1] = fault_master_lost_guarding; // RULE12
		ev[2] = fault_master_lost_heartbeat; // RULE13
		ev[3] = mode_bad; // RULE14
		ev[4] = fault_index_pulse_lost; // RULE15
		ev[5] = position_deviation && power_stage_enabled; // RULE16
		ev[6] = fault_internal_write_error; // RULE17
		ec_tab[0] = CSAF_EC_INVALID_ENABLE;
		ax_tab[0] = CSAF_AX_INVALID_ENABLE;
		ec_tab[1] = CSAF_EC_LOST_GUARD;
		ax_tab[1] = CSAF_AX_LOST_GUARD;
		ec_tab[2] = CSAF_EC_LOST_HBEAT;
		ax_tab[2] = CSAF_AX_LOST_HBEAT;
		ec_tab[3] = CSAF_EC_MODE_UNSUP;
		ax_tab[3] = CSAF_AX_MODE_UNSUP;
		ec_tab[4] = CSAF_EC_INDEX_PULSE;
		ax_tab[4] = CSAF_AX_INDEX_PULSE;
		ec_tab[5] = CSAF_EC_POS_DEV;
		ax_tab[5] = CSAF_AX_POS_DEV;
		ec_tab[6] = CSAF_EC_INTERNAL_WRITE;
		ax_tab[6] = CSAF_AX_INTERNAL_WRITE;
	end

	genvar gi;
	generate
		for (gi = 0; gi < CSAF_NUM_FAULTS; gi++) begin : g_slot
			csaf_fault_latch u_latch (
				.mclk(mclk),
				.arst_n(arst_n),
				.event_in(ev[gi]),
				.clear(fault_clear),
				.active(act[gi]),
				.new_event(fresh[gi])
			);
		end
	endgenerate

	// Lowest slot wins when several faults start in the same cycle
	always_comb begin
		fv_d = 1'b0;
		fc_d = fc_q;
		fx_d = fx_q;
		for (int i = CSAF_NUM_FAULTS - 1; i >= 0; i--) begin
			if (fresh[i]) begin
				fv_d = 1'b1;
				fc_d = ec_tab[i]; // RULE11
				fx_d = ax_tab[i]; // RULE11
			end
		end
		fa_d = |act;
		// Word reads zero while reset is held, then shows the fixed mode set
		ms_d = CSAF_MODES_SUPPORTED; // RULE18
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			fv_q <= 1'b0;
			fc_q <= 16'h0000;
			fx_q <= 32'h0000_0000;
			fa_q <= 1'b0;
			ms_q <= 16'h0000;
		end else begin
			fv_q <= fv_d;
			fc_q <= fc_d;
			fx_q <= fx_d;
			fa_q <= fa_d;
			ms_q <= ms_d;
		end
	end

	assign resp_valid = resp_valid_q;
	assign resp_cmd = resp_cmd_q;
	assign resp_data = resp_data_q;
	assign od_write = od_write_q;
	assign od_write_data = wdata_q;
	assign modes_supported = ms_q;
	assign fault_valid = fv_q;
	assign fault_code = fc_q;
	assign fault_aux = fx_q;
	assign fault_active = fa_q;

	a_bad_cmd_abort: assert property (@(posedge mclk) disable iff (!arst_n) // RULE1
		req_valid && req_cmd != 8'h40 && req_cmd != 8'h2F && req_cmd != 8'h2B && req_cmd != 8'h23
		|=> resp_valid && resp_cmd == 8'h80 && resp_data == 32'h0504_0001)
		else $error("bad specifier not aborted");
	a_ro_refused: assert property (@(posedge mclk) disable iff (!arst_n) // RULE2
		req_valid && req_cmd == 8'h23 && od_desc[1:0] == 2'h1
		&& req_subindex <= {5'h00, od_desc[7:5]} |=> !od_write && resp_data == 32'h0601_0002)
		else $error("read-only write not refused");
	a_no_object: assert property (@(posedge mclk) disable iff (!arst_n) // RULE3
		req_valid && (req_cmd == 8'h40 || req_cmd == 8'h23) && !od_desc[0]
		|=> resp_valid && resp_data == 32'h0602_0000)
		else $error("missing object not aborted");
	a_no_subindex: assert property (@(posedge mclk) disable iff (!arst_n) // RULE4
		req_valid && (req_cmd == 8'h40 || req_cmd == 8'h23) && od_desc[0]
		&& req_subindex > {5'h00, od_desc[7:5]} |=> resp_cmd == 8'h80 && resp_data == 32'h0609_0011)
		else $error("missing sub-index not aborted");
	a_len_abort: assert property (@(posedge mclk) disable iff (!arst_n) // RULE7
		req_valid && req_cmd == 8'h2F && od_desc[4:0] == 5'h17 && od_type_ok && req_index != 16'h6502
		&& req_subindex <= {5'h00, od_desc[7:5]} |=> !od_write && resp_data == 32'h0607_0010)
		else $error("length mismatch not aborted");
	a_enable_code: assert property (@(posedge mclk) disable iff (!arst_n) // RULE11
		$rose(act[0]) |=> fault_valid && fault_code == 16'h600D && fault_aux == 32'h0000_00B0)
		else $error("invalid enable code wrong");
	a_abort_no_write: assert property (@(posedge mclk) disable iff (!arst_n) // RULE19
		resp_valid && resp_cmd == 8'h80 |-> !od_write)
		else $error("write strobe with abort");
	a_write_confirm: assert property (@(posedge mclk) disable iff (!arst_n) // RULE19
		od_write |-> resp_valid && resp_cmd == 8'h60 && od_write_data == $past(req_data))
		else $error("write without confirmation");
	a_guard_code: assert property (@(posedge mclk) disable iff (!arst_n) // RULE12
		$rose(act[1]) && act[0] == 1'b0 |=> fault_valid && fault_code == 16'h6064
		&& fault_aux == 32'h0000_0E20)
		else $error("guarding loss code wrong");
	a_hbeat_code: assert property (@(posedge mclk) disable iff (!arst_n) // RULE13
		$rose(act[2]) && act[1:0] == 2'b00 |=> fault_code == 16'h6065 && fault_aux == 32'h0000_0E21)
		else $error("heartbeat loss code wrong");
	a_mode_bad: assert property (@(posedge mclk) disable iff (!arst_n) // RULE14
		mode_request_valid && mode_request == 8'h01 && !act[3] && ev[2:0] == 3'b000
		|=> ##1 fault_code == 16'h605A)
		else $error("unsupported mode not reported");
	a_dev_gated: assert property (@(posedge mclk) disable iff (!arst_n) // RULE16
		$rose(act[5]) |-> $past(power_stage_enabled))
		else $error("deviation fault without enable");
	a_mode_word: assert property (@(posedge mclk) disable iff (!arst_n) // RULE18
		$past(arst_n) |-> modes_supported == 16'h006D)
		else $error("supported mode word wrong");
endmodule : csaf_checker
`default_nettype wire

//--- verilog/csaf_fault_latch.sv
/*
 One sticky fault slot: a qualified fault event latches until cleared,
 with the event winning over a clear in the same cycle.
 Assumes the event and clear come from logic on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module csaf_fault_latch (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic event_in,
	input wire logic clear,
	output logic active,
	output logic new_event
);
	logic act_q, act_d, new_q, new_d;
	always_comb begin
		new_d = event_in && !act_q;
		act_d = event_in ? 1'b1 : (clear ? 1'b0 : act_q);
	end
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			act_q <= 1'b0;
			new_q <= 1'b0;
		end else begin
			act_q <= act_d;
			new_q <= new_d;
		end
	end
	assign active = act_q;
	assign new_event = new_q;
endmodule : csaf_fault_latch
`default_nettype wire

//--- verilog/csaf_pkg.sv
/*
 Shared constants for the service-data access checker and fault reporter:
 command specifiers, abort codes, fault error and auxiliary codes, the
 supported-mode word and object-dictionary field layout.
 Assumes a single 25 MHz logic clock and no software-visible registers.
*/
`default_nettype none
package csaf_pkg;
	// Accepted command specifiers
	localparam logic [7:0] CSAF_CS_UPLOAD = 8'h40;
	localparam logic [7:0] CSAF_CS_DNLD1 = 8'h2F;
	localparam logic [7:0] CSAF_CS_DNLD2 = 8'h2B;
	localparam logic [7:0] CSAF_CS_DNLD4 = 8'h23;
	// Abort codes
	localparam logic [31:0] CSAF_AB_NONE = 32'h0000_0000;
	localparam logic [31:0] CSAF_AB_BAD_CS = 32'h0504_0001;
	localparam logic [31:0] CSAF_AB_READ_ONLY = 32'h0601_0002;
	localparam logic [31:0] CSAF_AB_NO_OBJECT = 32'h0602_0000;
	localparam logic [31:0] CSAF_AB_NOT_MAPPABLE = 32'h0604_0041;
	localparam logic [31:0] CSAF_AB_MAP_TOO_LONG = 32'h0604_0042;
	localparam logic [31:0] CSAF_AB_LEN_MISMATCH = 32'h0607_0010;
	localparam logic [31:0] CSAF_AB_TYPE_MISMATCH = 32'h0607_0012;
	localparam logic [31:0] CSAF_AB_NO_SUBINDEX = 32'h0609_0011;
	localparam logic [31:0] CSAF_AB_TOO_HIGH = 32'h0609_0031;
	localparam logic [31:0] CSAF_AB_TOO_LOW = 32'h0609_0032;
	// Fault error and auxiliary codes
	localparam logic [15:0] CSAF_EC_INVALID_ENABLE = 16'h600D;
	localparam logic [31:0] CSAF_AX_INVALID_ENABLE = 32'h0000_00B0;
	localparam logic [15:0] CSAF_EC_INTERNAL_WRITE = 16'h603B;
	localparam logic [31:0] CSAF_AX_INTERNAL_WRITE = 32'h0000_0BF2;
	localparam logic [15:0] CSAF_EC_INDEX_PULSE = 16'h604A;
	localparam logic [31:0] CSAF_AX_INDEX_PULSE = 32'h0000_0C92;
	localparam logic [15:0] CSAF_EC_POS_DEV = 16'h6051;
	localparam logic [31:0] CSAF_AX_POS_DEV = 32'h0000_0D01;
	localparam logic [15:0] CSAF_EC_MODE_UNSUP = 16'h605A;
	localparam logic [31:0] CSAF_AX_MODE_UNSUP = 32'h0000_0E05;
	localparam logic [15:0] CSAF_EC_LOST_GUARD = 16'h6064;
	localparam logic [31:0] CSAF_AX_LOST_GUARD = 32'h0000_0E20;
	localparam logic [15:0] CSAF_EC_LOST_HBEAT = 16'h6065;
	localparam logic [31:0] CSAF_AX_LOST_HBEAT = 32'h0000_0E21;
	localparam int CSAF_NUM_FAULTS = 7;
	// Supported running modes: profile position, velocity, torque, homing, interpolation
	localparam logic [15:0] CSAF_MODES_SUPPORTED = 16'h006D;
	localparam logic [15:0] CSAF_MODES_INDEX = 16'h6502;
	// Object descriptor field layout: [0] exists, [1] writable, [2] mappable,
	// [4:3] size code (0=1,1=2,2=4 bytes), [7:5] highest sub-index
	localparam int CSAF_OD_EXISTS = 0;
	localparam int CSAF_OD_WRITABLE = 1;
	localparam int CSAF_OD_MAPPABLE = 2;
	localparam int CSAF_OD_SIZE_LO = 3;
	localparam int CSAF_OD_MAXSUB_LO = 5;
	localparam int CSAF_PDO_MAX_BITS = 64;
	localparam int CSAF_PDO_MAX_OBJECTS = 8;
	// Response timing
	localparam int CSAF_RESP_CYCLES = 2;
	localparam logic [7:0] CSAF_CS_ABORT = 8'h80;
	localparam logic [7:0] CSAF_CS_DNLD_ACK = 8'h60;
	localparam logic [7:0] CSAF_CS_UPLD_ACK = 8'h43;
	typedef enum logic [1:0] {CSAF_SZ_1, CSAF_SZ_2, CSAF_SZ_4, CSAF_SZ_BAD} csaf_size_e;
endpackage : csaf_pkg
`default_nettype wire
